// *** hdl/dmt_defines.svh ***
// Offsets, field positions, reset values and counts of the adaptive control
`ifndef DMT_DEFINES_SVH
`define DMT_DEFINES_SVH

// Byte offsets on the register bus
`define DMT_CTRL1_OFS       5'h00
`define DMT_CTRL2_OFS       5'h04
`define DMT_STATUS_OFS      5'h08
`define DMT_MASK_OFS        5'h0c
`define DMT_OPPT_OFS        5'h10
`define DMT_FSTART_OFS      5'h14
`define DMT_LIMIT_OFS       5'h18

// Control register one fields
`define DMT_R2_MSB_BIT      0
`define DMT_GUARD_BIT       1
`define DMT_CAPTURE_LSB     2
`define DMT_ADAPT_LSB       5

// Control register two fields
`define DMT_R1_CODE_LSB     0
`define DMT_LOC_CODE_LSB    3
`define DMT_R2_LOW_LSB      6
`define DMT_LOCK_BIT        8
`define DMT_ALERT_EN_BIT    9
`define DMT_CTRL2_W         10

// Status and mask fields
`define DMT_ST_CAPTURE      0
`define DMT_ST_UNDERVOLT    1
`define DMT_ST_ADJUST       2
`define DMT_ST_W            3

// Reset values
`define DMT_CTRL1_RST       8'h00
`define DMT_CTRL2_RST       10'h000
`define DMT_OPPT_RST        8'h64
`define DMT_FSTART_RST      8'h5a
`define DMT_CORE_LIM_RST    8'h00
`define DMT_ZONE_LO_RST     8'h28
`define DMT_ZONE_HI_RST     8'h64

// Monitoring cycles before a step at interval code zero
`define DMT_DEC_BASE        12'h008
`define DMT_INC_BASE        12'h010
`endif

// *** hdl/dmt_pkg.sv ***
// Types shared by the adaptive fan-start control logic
package dmt_pkg;
	typedef enum logic [1:0] {ADJ_HOLD, ADJ_DOWN, ADJ_UP} adj_dir_t;
	typedef logic [7:0] temp_t;
	typedef logic [11:0] cycles_t;
endpackage

// *** hdl/dynamic_min_temp_control_config.sv ***
// Adaptive fan-start temperature control register bank
//
// What this block does
// - Bit 0 holds remote-2 interval code MSB
// - Interval code sets monitoring cycles between adjustments
// - Guarded core undervoltage sets status bit 1
// - Guarded undervoltage raises alert when alerts enabled
// - Guarded undervoltage suspends hot monitoring and adaptation
// - Guarded undervoltage blocks entry to shutdown
// - Voltage back at or above limit restores all but status bit 1, which stays set until cleared
// - Bit 2 captures remote-1 temperature on alarm
// - Bit 3 captures local temperature on alarm
// - Bit 4 captures remote-2 temperature on alarm
// - Capture bit clear leaves operating point alone
// - Bit 5 adapts remote-1 fan-start temperature
// - Bit 6 adapts local fan-start temperature
// - Bit 7 adapts remote-2 fan-start temperature
// - Adapt bit clear keeps fan-start temperature fixed
// - Lock bit makes register read-only
// - Code 000 is 8 down, 16 up, doubling
// - Register clears to zero at reset
`timescale 1ns/1ps
`include "dmt_defines.svh"

module dynamic_min_temp_control_config (
	input  wire logic        i_mclk,
	input  wire logic        i_resetn,
	input  wire logic [4:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	output logic      [31:0] o_avs_readdata,
	output logic             o_avs_waitrequest,
	input  wire logic        i_monitor_tick,
	input  wire logic [7:0]  i_temp_remote1,
	input  wire logic [7:0]  i_temp_local,
	input  wire logic [7:0]  i_temp_remote2,
	input  wire logic [7:0]  i_core_voltage_input,
	input  wire logic        i_thermal_alarm_pin_n,
	input  wire logic        i_shutdown_req,
	output logic             o_irq,
	output logic             o_smbalert,
	output logic             o_processor_hot_monitor_en,
	output logic             o_shutdown_en,
	output logic      [23:0] o_fan_start_temperature,
	output logic      [2:0]  o_adaptive_active
);
	import dmt_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [31:0] merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				res[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return res;
	endfunction

	function automatic cycles_t period(input logic [2:0] code,
		input logic up);
		cycles_t base;
		base = up ? `DMT_INC_BASE : `DMT_DEC_BASE;
		return cycles_t'(base << code);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Registers and wires

	logic [7:0]              ctrl1_r;
	logic [`DMT_CTRL2_W-1:0] ctrl2_r;
	logic [`DMT_ST_W-1:0]    status_r;
	logic [`DMT_ST_W-1:0]    mask_r;
	temp_t                   oppt_r [3];
	temp_t                   fstart_r [3];
	temp_t                   core_lim_r;
	temp_t                   zone_lo_r;
	temp_t                   zone_hi_r;
	logic                    wait_r;
	logic                    alarm_s1_r;
	logic                    alarm_s2_r;
	logic                    alarm_prev_r;
	logic                    guard_active_r;
	cycles_t                 cnt_r [3];
	adj_dir_t                dir_r [3];
	logic [31:0]             rd_nxt;
	logic                    commit;
	logic                    wr_ctrl1;
	logic                    wr_ctrl2;
	logic                    wr_status;
	logic                    wr_mask;
	logic                    wr_oppt;
	logic                    wr_fstart;
	logic                    wr_limit;
	logic                    alarm_edge;
	logic                    lock;
	logic                    guard_nxt;
	temp_t                   temp [3];
	logic [2:0]              code [3];
	logic [2:0]              run;
	logic [2:0]              fire;
	adj_dir_t                dir_now [3];
	logic [`DMT_ST_W-1:0]    st_set;

	assign temp[0] = i_temp_remote1;
	assign temp[1] = i_temp_local;
	assign temp[2] = i_temp_remote2;
	assign lock    = ctrl2_r[`DMT_LOCK_BIT];

	////////////////////////////////////////////////////////////////////////
	// Avalon slave: one wait cycle, commit on the cycle waitrequest is low

	assign commit    = i_avs_write & ~wait_r;
	assign wr_ctrl1  = commit && i_avs_address[4:2] == `DMT_CTRL1_OFS >> 2;
	assign wr_ctrl2  = commit && i_avs_address[4:2] == `DMT_CTRL2_OFS >> 2;
	assign wr_status = commit && i_avs_address[4:2] == `DMT_STATUS_OFS >> 2;
	assign wr_mask   = commit && i_avs_address[4:2] == `DMT_MASK_OFS >> 2;
	assign wr_oppt   = commit && i_avs_address[4:2] == `DMT_OPPT_OFS >> 2;
	assign wr_fstart = commit && i_avs_address[4:2] == `DMT_FSTART_OFS >> 2;
	assign wr_limit  = commit && i_avs_address[4:2] == `DMT_LIMIT_OFS >> 2;

	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			wait_r <= 1'b1;
		end else begin
			wait_r <= ~((i_avs_read | i_avs_write) & wait_r);
		end
	end

	always_comb begin
		rd_nxt = 32'h0000_0000;
		case (i_avs_address[4:2])
		3'(`DMT_CTRL1_OFS >> 2): rd_nxt[7:0] = ctrl1_r;
		3'(`DMT_CTRL2_OFS >> 2): rd_nxt[`DMT_CTRL2_W-1:0] = ctrl2_r;
		3'(`DMT_STATUS_OFS >> 2): rd_nxt[`DMT_ST_W-1:0] = status_r;
		3'(`DMT_MASK_OFS >> 2): rd_nxt[`DMT_ST_W-1:0] = mask_r;
		3'(`DMT_OPPT_OFS >> 2): rd_nxt[23:0] = {oppt_r[2], oppt_r[1],
			oppt_r[0]};
		3'(`DMT_FSTART_OFS >> 2): rd_nxt[23:0] = {fstart_r[2],
			fstart_r[1], fstart_r[0]};
		3'(`DMT_LIMIT_OFS >> 2): rd_nxt[23:0] = {zone_hi_r, zone_lo_r,
			core_lim_r};
		default: rd_nxt = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			o_avs_readdata <= 32'h0000_0000;
		end else if (i_avs_read & wait_r) begin
			o_avs_readdata <= rd_nxt;
		end
	end

	assign o_avs_waitrequest = wait_r;

	////////////////////////////////////////////////////////////////////////
	// Configuration registers

	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			ctrl1_r <= `DMT_CTRL1_RST;
		end else if (wr_ctrl1 && !lock) begin
			ctrl1_r <= 8'(merge({24'h00_0000, ctrl1_r}, i_avs_writedata,
				i_avs_byteenable));
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			ctrl2_r <= `DMT_CTRL2_RST;
		end else if (wr_ctrl2 && !lock) begin
			ctrl2_r <= `DMT_CTRL2_W'(merge({22'h00_0000, ctrl2_r},
				i_avs_writedata, i_avs_byteenable));
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			mask_r     <= '0;
			core_lim_r <= `DMT_CORE_LIM_RST;
			zone_lo_r  <= `DMT_ZONE_LO_RST;
			zone_hi_r  <= `DMT_ZONE_HI_RST;
		end else begin
			if (wr_mask && i_avs_byteenable[0]) begin
				mask_r <= i_avs_writedata[`DMT_ST_W-1:0];
			end
			if (wr_limit) begin
				{zone_hi_r, zone_lo_r, core_lim_r} <= 24'(merge({8'h00,
					zone_hi_r, zone_lo_r, core_lim_r}, i_avs_writedata,
					i_avs_byteenable));
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Core undervoltage guard

	assign guard_nxt = ctrl1_r[`DMT_GUARD_BIT] &
		(i_core_voltage_input < core_lim_r);

	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			guard_active_r <= 1'b0;
		end else begin
			guard_active_r <= guard_nxt;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			o_smbalert                 <= 1'b0;
			o_processor_hot_monitor_en <= 1'b1;
			o_shutdown_en              <= 1'b0;
		end else begin
			o_smbalert <= guard_active_r &
				ctrl2_r[`DMT_ALERT_EN_BIT];
			o_processor_hot_monitor_en <= ~guard_active_r;
			o_shutdown_en <= i_shutdown_req & ~guard_active_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Thermal alarm pin: synchronise, then detect assertion

	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			alarm_s1_r   <= 1'b1;
			alarm_s2_r   <= 1'b1;
			alarm_prev_r <= 1'b1;
		end else begin
			alarm_s1_r   <= i_thermal_alarm_pin_n;
			alarm_s2_r   <= alarm_s1_r;
			alarm_prev_r <= alarm_s2_r;
		end
	end

	assign alarm_edge = ~alarm_s2_r & alarm_prev_r;

	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			for (int i = 0; i < 3; i++) begin
				oppt_r[i] <= `DMT_OPPT_RST;
			end
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (alarm_edge && ctrl1_r[`DMT_CAPTURE_LSB+i]) begin
					oppt_r[i] <= temp[i];
				end else if (wr_oppt && !lock && i_avs_byteenable[i]) begin
					oppt_r[i] <= i_avs_writedata[8*i +: 8];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Adaptive fan-start temperature

	assign code[0] = ctrl2_r[`DMT_R1_CODE_LSB +: 3];
	assign code[1] = ctrl2_r[`DMT_LOC_CODE_LSB +: 3];
	assign code[2] = {ctrl1_r[`DMT_R2_MSB_BIT],
		ctrl2_r[`DMT_R2_LOW_LSB +: 2]};

	always_comb begin
		for (int i = 0; i < 3; i++) begin
			run[i] = ctrl1_r[`DMT_ADAPT_LSB+i] & ~guard_active_r;
			if (temp[i] > oppt_r[i] && fstart_r[i] > zone_lo_r) begin
				dir_now[i] = ADJ_DOWN;
			end else if (temp[i] < oppt_r[i] && fstart_r[i] < zone_hi_r) begin
				dir_now[i] = ADJ_UP;
			end else begin
				dir_now[i] = ADJ_HOLD;
			end
			fire[i] = i_monitor_tick && run[i] && dir_now[i] != ADJ_HOLD &&
				dir_now[i] == dir_r[i] && cycles_t'(cnt_r[i] + 12'h001) >=
				period(code[i], dir_now[i] == ADJ_UP);
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			for (int i = 0; i < 3; i++) begin
				cnt_r[i] <= '0;
				dir_r[i] <= ADJ_HOLD;
			end
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (!run[i]) begin
					cnt_r[i] <= '0;
					dir_r[i] <= ADJ_HOLD;
				end else if (i_monitor_tick) begin
					if (dir_now[i] != dir_r[i] || fire[i]) begin
						cnt_r[i] <= '0;
					end else if (dir_now[i] != ADJ_HOLD) begin
						cnt_r[i] <= cycles_t'(cnt_r[i] + 12'h001);
					end
					dir_r[i] <= dir_now[i];
				end
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			for (int i = 0; i < 3; i++) begin
				fstart_r[i] <= `DMT_FSTART_RST;
			end
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (wr_fstart && i_avs_byteenable[i]) begin
					fstart_r[i] <= i_avs_writedata[8*i +: 8];
				end else if (fire[i]) begin
					fstart_r[i] <= (dir_r[i] == ADJ_UP) ?
						8'(fstart_r[i] + 8'h01) : 8'(fstart_r[i] - 8'h01);
				end
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			o_fan_start_temperature <= {3{`DMT_FSTART_RST}};
			o_adaptive_active       <= 3'h0;
		end else begin
			o_fan_start_temperature <= {fstart_r[2], fstart_r[1],
				fstart_r[0]};
			o_adaptive_active <= run;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt status, set wins over write-one-to-clear

	always_comb begin
		st_set = '0;
		st_set[`DMT_ST_CAPTURE] = alarm_edge & |ctrl1_r[`DMT_CAPTURE_LSB +: 3];
		st_set[`DMT_ST_UNDERVOLT] = guard_active_r;
		st_set[`DMT_ST_ADJUST] = |fire;
	end

	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			status_r <= '0;
			o_irq    <= 1'b0;
		end else begin
			status_r <= (status_r & ~((wr_status && i_avs_byteenable[0]) ?
				i_avs_writedata[`DMT_ST_W-1:0] : '0)) | st_set;
			o_irq <= |(status_r & mask_r);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);

	guard_status_a: assert property (
		guard_active_r |=> status_r[`DMT_ST_UNDERVOLT])
		else $error("undervolt status not set");

	alert_raise_a: assert property (
		guard_active_r && ctrl2_r[`DMT_ALERT_EN_BIT] |=> o_smbalert)
		else $error("alert not raised on guarded undervolt");

	hot_suspend_a: assert property (
		guard_active_r |=> !o_processor_hot_monitor_en &&
			o_adaptive_active == 3'h0)
		else $error("monitoring not suspended");

	shutdown_block_a: assert property (
		guard_active_r |=> !o_shutdown_en)
		else $error("shutdown allowed under undervolt");

	restore_on_a: assert property (
		$fell(guard_active_r) |=> o_processor_hot_monitor_en)
		else $error("hot monitoring not restored");

	guard_off_a: assert property (
		!ctrl1_r[`DMT_GUARD_BIT] |=> !guard_active_r ##1 !o_smbalert)
		else $error("guard acted while disabled");

	lock_hold_a: assert property (
		lock && !alarm_edge |=> $stable(ctrl1_r) && $stable(oppt_r[0]))
		else $error("locked register changed");

	for (genvar g = 0; g < 3; g++) begin : g_chk
		alarm_capture_a: assert property (
			alarm_edge && ctrl1_r[`DMT_CAPTURE_LSB+g] |=>
				oppt_r[g] == $past(temp[g]))
			else $error("operating point not captured");
		capture_off_a: assert property (
			!ctrl1_r[`DMT_CAPTURE_LSB+g] && !wr_oppt |=> $stable(oppt_r[g]))
			else $error("operating point changed without capture");
		adapt_fixed_a: assert property (
			!run[g] && !wr_fstart |=> $stable(fstart_r[g]))
			else $error("fan start moved while adaptation off");
		adapt_step_a: assert property (
			fire[g] && !wr_fstart |=> fstart_r[g] != $past(fstart_r[g]))
			else $error("fan start not stepped");
		interval_a: assert property (
			fire[g] |-> cnt_r[g] >= cycles_t'(`DMT_DEC_BASE - 12'h001))
			else $error("adjustment before least interval");
	end
endmodule

// *** tb/dmt_host_model.sv ***
// Register bus master and thermal alarm source facing the control block
`timescale 1ns/1ps

module dmt_host_model (
	input  wire logic        i_mclk,
	input  wire logic        i_waitrequest,
	input  wire logic [31:0] i_readdata,
	output logic      [4:0]  o_address,
	output logic             o_read,
	output logic             o_write,
	output logic      [31:0] o_writedata,
	output logic      [3:0]  o_byteenable,
	output logic             o_alarm_n
);
	initial begin
		o_address    = 5'h00;
		o_read       = 1'b0;
		o_write      = 1'b0;
		o_writedata  = 32'h0000_0000;
		o_byteenable = 4'hf;
		o_alarm_n    = 1'b1;
	end

	task automatic bus_write(input logic [4:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		o_address   <= a;
		o_writedata <= d;
		o_write     <= 1'b1;
		do @(posedge i_mclk); while (i_waitrequest !== 1'b0);
		o_write     <= 1'b0;
		o_writedata <= ~d;
	endtask

	task automatic bus_read(input logic [4:0] a, output logic [31:0] d);
		@(posedge i_mclk);
		o_address <= a;
		o_read    <= 1'b1;
		do @(posedge i_mclk); while (i_waitrequest !== 1'b0);
		d = i_readdata;
		o_read <= 1'b0;
	endtask

	// Alarm held low long enough to pass the synchroniser, then released
	task automatic alarm_pulse();
		@(posedge i_mclk);
		o_alarm_n <= 1'b0;
		repeat (6) @(posedge i_mclk);
		o_alarm_n <= 1'b1;
		repeat (4) @(posedge i_mclk);
	endtask
endmodule

// *** tb/dynamic_min_temp_control_config_tb.sv ***
// Self-checking bench for the adaptive fan-start control register bank
`timescale 1ns/1ps
`include "dmt_defines.svh"

module dynamic_min_temp_control_config_tb;
	logic        i_mclk;
	logic        i_resetn;
	logic [4:0]  adr;
	logic        rd;
	logic        avs_wr;
	logic [31:0] wdata;
	logic [3:0]  be;
	logic [31:0] rdata;
	logic        wait_req;
	logic        tick;
	logic [7:0]  t_r1;
	logic [7:0]  t_loc;
	logic [7:0]  t_r2;
	logic [7:0]  vcore;
	logic        alarm_n;
	logic        shut_req;
	logic        irq;
	logic        alert;
	logic        hot_en;
	logic        shut_en;
	logic [23:0] fstart;
	logic [2:0]  adapt;
	logic [31:0] v;
	int          miscompares;
	int          tests_run;

	dynamic_min_temp_control_config dynamic_min_temp_control_config_i (
		.i_mclk(i_mclk), .i_resetn(i_resetn),
		.i_avs_address(adr), .i_avs_read(rd), .i_avs_write(avs_wr),
		.i_avs_writedata(wdata), .i_avs_byteenable(be),
		.o_avs_readdata(rdata), .o_avs_waitrequest(wait_req),
		.i_monitor_tick(tick), .i_temp_remote1(t_r1),
		.i_temp_local(t_loc), .i_temp_remote2(t_r2),
		.i_core_voltage_input(vcore), .i_thermal_alarm_pin_n(alarm_n),
		.i_shutdown_req(shut_req), .o_irq(irq), .o_smbalert(alert),
		.o_processor_hot_monitor_en(hot_en), .o_shutdown_en(shut_en),
		.o_fan_start_temperature(fstart), .o_adaptive_active(adapt));

	dmt_host_model dmt_host_model_i (
		.i_mclk(i_mclk), .i_waitrequest(wait_req), .i_readdata(rdata),
		.o_address(adr), .o_read(rd), .o_write(avs_wr),
		.o_writedata(wdata), .o_byteenable(be), .o_alarm_n(alarm_n));

	initial begin
		i_mclk = 1'b0;
		forever #4 i_mclk = ~i_mclk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [31:0] exp,
			input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic reg_chk(input string name, input logic [4:0] a,
			input logic [31:0] exp);
		dmt_host_model_i.bus_read(a, v);
		check(name, exp, v);
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		dmt_host_model_i.bus_write(a, d);
	endtask

	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge i_mclk);
			tick <= 1'b1;
			@(posedge i_mclk);
			tick <= 1'b0;
			repeat (2) @(posedge i_mclk);
		end
		repeat (4) @(posedge i_mclk);
	endtask

	task automatic pins(input logic [31:0] exp);
		repeat (5) @(posedge i_mclk);
		check("pins", exp, {26'h0, alert, hot_en, shut_en, adapt});
	endtask

	task automatic summarize();
		if (miscompares == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge i_mclk);
		miscompares++;
		summarize();
	end

	initial begin
		miscompares = 0;
		tests_run   = 0;
		i_resetn    = 1'b0;
		tick        = 1'b0;
		t_r1        = 8'h30;
		t_loc       = 8'h31;
		t_r2        = 8'h32;
		vcore       = 8'h40;
		shut_req    = 1'b1;
		repeat (2) @(posedge i_mclk);
		i_resetn <= 1'b1;
		reg_chk("ctrl1", `DMT_CTRL1_OFS, 32'h0000_0000);
		check("fstart", 32'h005a_5a5a, {8'h0, fstart});
		wr(`DMT_CTRL1_OFS, 32'h0000_00ff);
		reg_chk("ctrl1", `DMT_CTRL1_OFS, 32'h0000_00ff);
		// Remote channels capture, local ignores the alarm
		wr(`DMT_CTRL1_OFS, 32'h0000_0014);
		dmt_host_model_i.alarm_pulse();
		reg_chk("oppt", `DMT_OPPT_OFS, 32'h0032_6430);
		wr(`DMT_CTRL1_OFS, 32'h0000_0008);
		t_r1 <= 8'h11;
		dmt_host_model_i.alarm_pulse();
		reg_chk("oppt", `DMT_OPPT_OFS, 32'h0032_3130);
		reg_chk("status", `DMT_STATUS_OFS, 32'h0000_0001);
		wr(`DMT_STATUS_OFS, 32'h0000_0001);
		reg_chk("status", `DMT_STATUS_OFS, 32'h0000_0000);
		// Undervoltage with the guard off, then on
		wr(`DMT_LIMIT_OFS, 32'h0064_2850);
		wr(`DMT_CTRL2_OFS, 32'h0000_0200);
		wr(`DMT_MASK_OFS, 32'h0000_0002);
		wr(`DMT_CTRL1_OFS, 32'h0000_00e0);
		pins(32'h0000_001f);
		reg_chk("status", `DMT_STATUS_OFS, 32'h0000_0000);
		check("irq", 32'h0, {31'h0, irq});
		wr(`DMT_CTRL1_OFS, 32'h0000_00e2);
		pins(32'h0000_0020);
		reg_chk("status", `DMT_STATUS_OFS, 32'h0000_0002);
		check("irq", 32'h1, {31'h0, irq});
		vcore <= 8'h60;
		pins(32'h0000_001f);
		wr(`DMT_STATUS_OFS, 32'h0000_0002);
		reg_chk("status", `DMT_STATUS_OFS, 32'h0000_0000);
		repeat (2) @(posedge i_mclk);
		check("irq", 32'h0, {31'h0, irq});
		// Remote-1: first tick sets direction, step 8 on, then 16 at code 1
		t_r1 <= 8'h40;
		wr(`DMT_CTRL1_OFS, 32'h0000_0020);
		ticks(8);
		check("fstart", 32'h005a_5a5a, {8'h0, fstart});
		ticks(1);
		check("fstart", 32'h005a_5a59, {8'h0, fstart});
		wr(`DMT_CTRL2_OFS, 32'h0000_0201);
		ticks(15);
		check("fstart", 32'h005a_5a59, {8'h0, fstart});
		ticks(1);
		check("fstart", 32'h005a_5a58, {8'h0, fstart});
		// Local rises at code 3, remote-2 falls at code 4 through the MSB
		t_loc <= 8'h20;
		t_r2  <= 8'h40;
		wr(`DMT_CTRL1_OFS, 32'h0000_00c1);
		wr(`DMT_CTRL2_OFS, 32'h0000_0218);
		ticks(128);
		check("fstart", 32'h005a_5a58, {8'h0, fstart});
		ticks(1);
		check("fstart", 32'h0059_5b58, {8'h0, fstart});
		reg_chk("ctrl1", `DMT_CTRL1_OFS, 32'h0000_00c1);
		// Lock freezes the register; unmapped reads as zero
		wr(`DMT_CTRL2_OFS, 32'h0000_0300);
		wr(`DMT_CTRL1_OFS, 32'h0000_0000);
		reg_chk("ctrl1", `DMT_CTRL1_OFS, 32'h0000_00c1);
		reg_chk("unmapped", 5'h1c, 32'h0000_0000);
		summarize();
	end
endmodule
